// ### epiu_top.v
/*
 * External pin interrupt unit: three pin sense units, enables, sticky
 * request flags, vector dispatch and an AXI4-Lite register slave.
 * Assumes a single 20 MHz clock, pins synchronous to it, and a CPU that
 * pulses vec_ack when it enters the routine for vec_num.
 */
// How it works
// - Pin a sense field selects low level, any change, falling or rising edge.
// - Pin a/b levels are sampled first and a pulse longer than a clock gives a request.
// - A pin interrupt is taken only with its enable and the global flag both set.
// - Pin c sense bit picks falling edge at zero, rising edge at one.
// - Pin c edges are caught by a plain edge detector and need no extra clock gate.
// - The enable register holds pin b at bit 7, pin a at bit 6, pin c at bit 5.
// - Pin activity raises a request whatever the pin direction is.
// - Each pin has its own vector number.
// - The flag register holds pin b at bit 7, pin a at bit 6, pin c at bit 5, set on events.
// - A flag clears when its vector is acknowledged or when software writes one to it.
// - A pin in level mode keeps its flag cleared.
// - A change of the pin c sense bit alone gives no spurious pin c flag; only pin edges are latched.
// - Pin b uses its own sense field at bits 3:2 with the same encodings.
// - Level detection on a/b and edge detection on c act directly on the pin sample.
`timescale 1ns/10ps
`include "epiu_regs.vh"
module epiu_top (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // External pins
    input  wire        ext_pin_a,
    input  wire        ext_pin_b,
    input  wire        ext_pin_c,
    // CPU interrupt side
    input  wire        vec_ack,
    output reg         irq,
    output reg  [1:0]  vec_num
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0] mcu_control_q;
    reg  [7:0] mcu_control_status_q;
    reg  [7:0] pin_irq_enable_q;
    reg  [7:0] pin_irq_flags_q;
    reg  [7:0] pin_irq_flags_d;
    reg  [7:0] cpu_status_reg_q;
    reg  [7:0] awaddr_q;
    reg        aw_held_q;
    reg  [31:0] wdata_q;
    reg  [3:0] wstrb_q;
    reg        w_held_q;

    wire [1:0] sense_a = mcu_control_q[`EPIU_SENSE_A_LSB+1:`EPIU_SENSE_A_LSB];
    wire [1:0] sense_b = mcu_control_q[`EPIU_SENSE_B_LSB+1:`EPIU_SENSE_B_LSB];
    wire       sense_c_edge = mcu_control_status_q[`EPIU_SENSE_C_BIT];

    wire       edge_a;
    wire       edge_b;
    wire       edge_c;
    wire       low_a;
    wire       low_b;

    // ------------------------------------------------------------------
    // Pin sense units
    // ------------------------------------------------------------------
    // Pin a, with direction never consulted
    epiu_sense u_sense_a (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin       (ext_pin_a),
        .sense     (sense_a),
        .edge_hit  (edge_a),
        .level_low (low_a)
    );

    // Pin b, own sense field
    epiu_sense u_sense_b (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin       (ext_pin_b),
        .sense     (sense_b),
        .edge_hit  (edge_b),
        .level_low (low_b)
    );

    // Pin c, edge only
    epiu_edge_c u_edge_c (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (ext_pin_c),
        .rise_sel (sense_c_edge),
        .edge_hit (edge_c)
    );

    // ------------------------------------------------------------------
    // Bus write path
    // ------------------------------------------------------------------
    wire       wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    wire       wr_ok   = wr_fire && wstrb_q[0];

    // Word select for one register offset, low two address bits ignored
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    wire       wr_known = hit(awaddr_q, `EPIU_OFS_MCU_CONTROL) ||
                          hit(awaddr_q, `EPIU_OFS_MCU_CONTROL_STATUS) ||
                          hit(awaddr_q, `EPIU_OFS_PIN_IRQ_ENABLE) ||
                          hit(awaddr_q, `EPIU_OFS_PIN_IRQ_FLAGS) ||
                          hit(awaddr_q, `EPIU_OFS_CPU_STATUS) ||
                          hit(awaddr_q, `EPIU_OFS_VECTOR_ACK) ||
                          hit(awaddr_q, `EPIU_OFS_PIN_LEVEL);

    wire       w1c_hit = wr_ok && hit(awaddr_q, `EPIU_OFS_PIN_IRQ_FLAGS);
    wire       ack_hit = wr_ok && hit(awaddr_q, `EPIU_OFS_VECTOR_ACK);
    wire       ack_any = vec_ack || ack_hit;

    // Address and data captured in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers, low byte lane only
    always @(posedge aclk) begin
        if (!aresetn) begin
            mcu_control_q        <= `EPIU_RST_BYTE;
            mcu_control_status_q <= `EPIU_RST_BYTE;
            pin_irq_enable_q     <= `EPIU_RST_BYTE;
            cpu_status_reg_q     <= `EPIU_RST_BYTE;
        end else if (wr_ok) begin
            if (hit(awaddr_q, `EPIU_OFS_MCU_CONTROL)) begin
                mcu_control_q <= wdata_q[7:0];
            end
            if (hit(awaddr_q, `EPIU_OFS_MCU_CONTROL_STATUS)) begin
                mcu_control_status_q <= wdata_q[7:0];
            end
            if (hit(awaddr_q, `EPIU_OFS_PIN_IRQ_ENABLE)) begin
                pin_irq_enable_q <= wdata_q[7:0] & 8'hE0;
            end
            if (hit(awaddr_q, `EPIU_OFS_CPU_STATUS)) begin
                cpu_status_reg_q <= wdata_q[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------------
    // Set wins over any clear in the same cycle
    always @* begin
        pin_irq_flags_d = pin_irq_flags_q;
        if (w1c_hit) begin
            pin_irq_flags_d = pin_irq_flags_q & ~(wdata_q[7:0] & 8'hE0);
        end
        if (ack_any) begin
            case (vec_num)
                `EPIU_VEC_A: pin_irq_flags_d[`EPIU_BIT_A] = 1'b0;
                `EPIU_VEC_B: pin_irq_flags_d[`EPIU_BIT_B] = 1'b0;
                `EPIU_VEC_C: pin_irq_flags_d[`EPIU_BIT_C] = 1'b0;
                default:     ;
            endcase
        end
        if (edge_a) pin_irq_flags_d[`EPIU_BIT_A] = 1'b1;
        if (edge_b) pin_irq_flags_d[`EPIU_BIT_B] = 1'b1;
        if (edge_c) pin_irq_flags_d[`EPIU_BIT_C] = 1'b1;
        if (sense_a == `EPIU_SENSE_LOW) pin_irq_flags_d[`EPIU_BIT_A] = 1'b0;
        if (sense_b == `EPIU_SENSE_LOW) pin_irq_flags_d[`EPIU_BIT_B] = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_irq_flags_q <= `EPIU_RST_BYTE;
        end else begin
            pin_irq_flags_q <= pin_irq_flags_d;
        end
    end

    // ------------------------------------------------------------------
    // Dispatch
    // ------------------------------------------------------------------
    wire gie   = cpu_status_reg_q[`EPIU_GIE_BIT];
    wire req_a = (pin_irq_flags_q[`EPIU_BIT_A] || low_a) && pin_irq_enable_q[`EPIU_BIT_A];
    wire req_b = (pin_irq_flags_q[`EPIU_BIT_B] || low_b) && pin_irq_enable_q[`EPIU_BIT_B];
    wire req_c = pin_irq_flags_q[`EPIU_BIT_C] && pin_irq_enable_q[`EPIU_BIT_C];

    // Fixed priority a, b, c; each to its own vector
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq     <= 1'b0;
            vec_num <= `EPIU_VEC_NONE;
        end else begin
            irq <= gie && (req_a || req_b || req_c);
            if (!gie) begin
                vec_num <= `EPIU_VEC_NONE;
            end else if (req_a) begin
                vec_num <= `EPIU_VEC_A;
            end else if (req_b) begin
                vec_num <= `EPIU_VEC_B;
            end else if (req_c) begin
                vec_num <= `EPIU_VEC_C;
            end else begin
                vec_num <= `EPIU_VEC_NONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                if (hit(s_axi_araddr, `EPIU_OFS_MCU_CONTROL)) begin
                    s_axi_rdata <= {24'h000000, mcu_control_q};
                end else if (hit(s_axi_araddr, `EPIU_OFS_MCU_CONTROL_STATUS)) begin
                    s_axi_rdata <= {24'h000000, mcu_control_status_q};
                end else if (hit(s_axi_araddr, `EPIU_OFS_PIN_IRQ_ENABLE)) begin
                    s_axi_rdata <= {24'h000000, pin_irq_enable_q};
                end else if (hit(s_axi_araddr, `EPIU_OFS_PIN_IRQ_FLAGS)) begin
                    s_axi_rdata <= {24'h000000, pin_irq_flags_q};
                end else if (hit(s_axi_araddr, `EPIU_OFS_CPU_STATUS)) begin
                    s_axi_rdata <= {24'h000000, cpu_status_reg_q};
                end else if (hit(s_axi_araddr, `EPIU_OFS_VECTOR_ACK)) begin
                    s_axi_rdata <= {30'h0, vec_num};
                end else if (hit(s_axi_araddr, `EPIU_OFS_PIN_LEVEL)) begin
                    s_axi_rdata <= {29'h0, ext_pin_c, ext_pin_b, ext_pin_a};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // epiu_top

// ### epiu_regs.vh
/*
 * Register map, field positions and reset values of the external pin
 * interrupt unit. Assumes a 32-bit AXI4-Lite register bus, byte addresses.
 */
`ifndef EPIU_REGS_VH
`define EPIU_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EPIU_OFS_MCU_CONTROL        8'h00
`define EPIU_OFS_MCU_CONTROL_STATUS 8'h04
`define EPIU_OFS_PIN_IRQ_ENABLE     8'h08
`define EPIU_OFS_PIN_IRQ_FLAGS      8'h0C
`define EPIU_OFS_CPU_STATUS         8'h10
`define EPIU_OFS_VECTOR_ACK         8'h14
`define EPIU_OFS_PIN_LEVEL          8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPIU_SENSE_A_LSB   0
`define EPIU_SENSE_B_LSB   2
`define EPIU_SENSE_C_BIT   6
`define EPIU_BIT_B         7
`define EPIU_BIT_A         6
`define EPIU_BIT_C         5
`define EPIU_GIE_BIT       7

// ----------------------------------------------------------------------
// Sense encodings and reset values
// ----------------------------------------------------------------------
`define EPIU_SENSE_LOW     2'h0
`define EPIU_SENSE_ANY     2'h1
`define EPIU_SENSE_FALL    2'h2
`define EPIU_SENSE_RISE    2'h3
`define EPIU_RST_BYTE      8'h00

// ----------------------------------------------------------------------
// Vector numbers presented on the vector output
// ----------------------------------------------------------------------
`define EPIU_VEC_NONE      2'h0
`define EPIU_VEC_A         2'h1
`define EPIU_VEC_B         2'h2
`define EPIU_VEC_C         2'h3

`endif

// ### epiu_sense.v
/*
 * Sense unit for one level or edge pin (pins a and b).
 * Assumes the pin input is synchronous to aclk as seen by this block.
 */
`timescale 1ns/10ps
module epiu_sense (
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Pin and mode
    input  wire       pin,
    input  wire [1:0] sense,
    // Results
    output reg        edge_hit,
    output reg        level_low
);
    reg sync1_q;
    reg sync2_q;
    reg prev_q;

    // Two-stage sampler then previous value for edge compare
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Decode the sense field into a request
    always @* begin
        level_low = (sense == `EPIU_SENSE_LOW) && !sync2_q;
        case (sense)
            `EPIU_SENSE_ANY:  edge_hit = sync2_q ^ prev_q;
            `EPIU_SENSE_FALL: edge_hit = prev_q & ~sync2_q;
            `EPIU_SENSE_RISE: edge_hit = ~prev_q & sync2_q;
            default:          edge_hit = 1'b0;
        endcase
    end
endmodule // epiu_sense

// ### epiu_edge_c.v
/*
 * Edge-only sense for pin c: programmable polarity edge detector.
 * Assumes pin input synchronous to aclk; captures any edge lasting one clock.
 */
`timescale 1ns/10ps
module epiu_edge_c (
    // Clock and reset
    input  wire aclk,
    input  wire aresetn,
    // Pin and polarity
    input  wire pin,
    input  wire rise_sel,
    // Result
    output reg  edge_hit
);
    reg prev_q;

    // Remember last level, seeded high like an idle pin so reset gives no edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= pin;
        end
    end

    // Edge of the selected polarity; a change of polarity alone never fires
    always @* begin
        if (rise_sel) begin
            edge_hit = pin & ~prev_q;
        end else begin
            edge_hit = ~pin & prev_q;
        end
    end
endmodule // epiu_edge_c

// ### epiu_props.sv
/*
 * Checker for the external pin interrupt unit, watching top-level ports only.
 * Assumes the bench writes whole words; bound to epiu_top at the foot.
 */
`timescale 1ns/10ps
`include "epiu_regs.vh"
module epiu_props (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // CPU side
    input wire        irq,
    input wire [1:0]  vec_num
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // Shadow of enables and global flag, taken when a write is answered
    // ----------------------------------------------------------------
    logic [7:0] wa_q;
    logic [7:0] wd_q;
    logic [2:0] en_q;
    logic       gie_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            en_q  <= 3'h0;
            gie_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd_q <= s_axi_wdata[7:0];
            if ($rose(s_axi_bvalid) && wa_q == `EPIU_OFS_PIN_IRQ_ENABLE)
                en_q <= wd_q[7:5];
            if ($rose(s_axi_bvalid) && wa_q == `EPIU_OFS_CPU_STATUS)
                gie_q <= wd_q[`EPIU_GIE_BIT];
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_rst_quiet;
        $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && vec_num == `EPIU_VEC_NONE;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("Outputs busy after reset");
    property p_irq_gate;
        irq |-> gie_q && en_q != 3'h0;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Request while masked");
    property p_vec_en;
        irq |-> (vec_num == `EPIU_VEC_A && en_q[1]) || (vec_num == `EPIU_VEC_B && en_q[2])
            || (vec_num == `EPIU_VEC_C && en_q[0]);
    endproperty
    a_vec_en: assert property (p_vec_en) else $error("Vector of a disabled pin");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("Write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("Read answer dropped");
    property p_ar_block;
        s_axi_rvalid |-> !(s_axi_arvalid && s_axi_arready);
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("Read taken while answer pending");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("Read answer late");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("Write answer late");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= (`EPIU_OFS_PIN_LEVEL + 8'h04)
            |-> ##[1:3] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not refused");
    // Main scenarios reached
    c_irq_c: cover property (irq && vec_num == `EPIU_VEC_C);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // epiu_props

bind epiu_top epiu_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .vec_num);

// ### epiu_pins.sv
/*
 * Model of the outside sources driving the three interrupt pins.
 * Assumes one caller at a time; pins idle high.
 */
`timescale 1ns/10ps
module epiu_pins (
    // Clock
    input  wire aclk,
    // Pins
    output reg  ext_pin_a = 1'b1,
    output reg  ext_pin_b = 1'b1,
    output reg  ext_pin_c = 1'b1
);
    // Change one pin after an edge, then keep it for n cycles
    task automatic hold(input int idx, input logic v, input int n);
        begin
            @(posedge aclk);
            if (idx == 0)
                ext_pin_a <= v;
            else if (idx == 1)
                ext_pin_b <= v;
            else
                ext_pin_c <= v;
            repeat (n) @(posedge aclk);
        end
    endtask
endmodule // epiu_pins

// ### epiu_test.sv
/*
 * Self-checking bench for the external pin interrupt unit.
 * Assumes the pin model epiu_pins and the bound checker.
 */
`timescale 1ns/10ps
`include "epiu_regs.vh"
module epiu_test;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        vec_ack       = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, vec_num;
    logic [31:0] s_axi_rdata;
    logic [7:0]  fb;
    wire         ext_pin_a, ext_pin_b, ext_pin_c;
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    epiu_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_pin_a, .ext_pin_b, .ext_pin_c, .vec_ack, .irq, .vec_num);
    epiu_pins u_pins (.aclk, .ext_pin_a, .ext_pin_b, .ext_pin_c);
    // ----------------------------------------------------------------
    // Clock, watchdog and verdict
    // ----------------------------------------------------------------
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            close_out();
        end
    end
    task automatic close_out;
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request line and vector, vector only looked at while requesting
    task automatic see(input logic ei, input logic [1:0] ev);
        chk({31'h0, irq}, {31'h0, ei});
        if (ei)
            chk({30'h0, vec_num}, {30'h0, ev});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        // Answer is left waiting a cycle before it is taken
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        chk(s_axi_rdata, {24'h0, ed});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped places, enable bits
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 8'h00, 2'h0);
        rd(8'h18, 8'h07, 2'h0);
        rd(8'h1C, 8'h00, 2'h2);
        wr(8'h1C, 8'h55, 2'h2);
        wr(8'h08, 8'hFF, 2'h0);
        rd(8'h08, 8'hE0, 2'h0);
        // Change, falling and rising sense on pins a and b
        for (int p = 0; p < 2; p++)
            for (int m = 1; m < 4; m++) begin
                fb = (p == 0) ? 8'h40 : 8'h80;
                wr(8'h00, 8'(m << (2 * p)), 2'h0);
                wr(8'h0C, 8'hE0, 2'h0);
                u_pins.hold(p, 1'b0, 4);
                rd(8'h0C, (m != 3) ? fb : 8'h00, 2'h0);
                wr(8'h0C, 8'hE0, 2'h0);
                u_pins.hold(p, 1'b1, 4);
                rd(8'h0C, (m != 2) ? fb : 8'h00, 2'h0);
            end
        // Level sense requests while low and keeps flags clear
        wr(8'h00, 8'h00, 2'h0);
        wr(8'h08, 8'hC0, 2'h0);
        wr(8'h10, 8'h80, 2'h0);
        u_pins.hold(1, 1'b0, 5);
        see(1'b1, `EPIU_VEC_B);
        rd(8'h0C, 8'h00, 2'h0);
        u_pins.hold(0, 1'b0, 5);
        see(1'b1, `EPIU_VEC_A);
        u_pins.hold(0, 1'b1, 1);
        u_pins.hold(1, 1'b1, 5);
        see(1'b0, 2'h0);
        // Falling edges on all pins, held off, masked, then taken in order
        wr(8'h10, 8'h00, 2'h0);
        wr(8'h00, 8'h0A, 2'h0);
        wr(8'h0C, 8'hE0, 2'h0);
        u_pins.hold(0, 1'b0, 0);
        u_pins.hold(1, 1'b0, 0);
        u_pins.hold(2, 1'b0, 5);
        rd(8'h0C, 8'hE0, 2'h0);
        see(1'b0, 2'h0);
        wr(8'h10, 8'h80, 2'h0);
        repeat (3) @(posedge aclk);
        see(1'b1, `EPIU_VEC_A);
        wr(8'h08, 8'h20, 2'h0);
        repeat (3) @(posedge aclk);
        see(1'b1, `EPIU_VEC_C);
        wr(8'h08, 8'hE0, 2'h0);
        for (int v = 1; v < 4; v++) begin
            repeat (3) @(posedge aclk);
            see(1'b1, 2'(v));
            if (v == 3) begin
                wr(8'h14, 8'h00, 2'h0);
            end else begin
                vec_ack <= 1'b1;
                @(posedge aclk);
                vec_ack <= 1'b0;
            end
        end
        repeat (3) @(posedge aclk);
        see(1'b0, 2'h0);
        rd(8'h0C, 8'h00, 2'h0);
        // Pin c moved to rising sense the safe way, then pulsed both ways
        wr(8'h08, 8'h00, 2'h0);
        wr(8'h04, 8'h40, 2'h0);
        wr(8'h0C, 8'h20, 2'h0);
        wr(8'h08, 8'h20, 2'h0);
        rd(8'h04, 8'h40, 2'h0);
        u_pins.hold(2, 1'b1, 2);
        rd(8'h0C, 8'h20, 2'h0);
        see(1'b1, `EPIU_VEC_C);
        wr(8'h0C, 8'h20, 2'h0);
        u_pins.hold(2, 1'b0, 3);
        see(1'b0, 2'h0);
        rd(8'h0C, 8'h00, 2'h0);
        close_out();
    end
endmodule // epiu_test
